// [wdt_top.sv]
// Watchdog controller with APB registers, modes and timed unlock.
// Assumes APB3 master on pclk; fuse and core strobes synchronous.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "wdt_defs.svh"
module wdt_top
    import wdt_pkg::*;
#(
    parameter int TICK_DIV   = `WDT_TICK_DIV,
    parameter int BASE_TICKS = `WDT_BASE_TICKS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        watchdog_always_on_fuse,
    input  wire logic        restart_req,
    input  wire logic        irq_ack,
    output logic             irq,
    output logic             wdt_reset_pulse,
    output logic             startup_delay_start
);
    logic [3:0]   period_r;
    logic [3:0]   per_nxt;
    logic         re_r;
    logic         re_nxt;
    logic         ie_r;
    logic         ie_nxt;
    logic         unlock_r;
    logic [1:0]   unl_cnt_r;
    logic         iflag_r;
    logic [1:0]   status_r;
    logic [1:0]   mask_r;
    logic         cause_r;
    logic         pulse_r;
    logic         start_r;
    logic [31:0]  prdata_r;
    logic [31:0]  rd_mux;
    logic         do_irq;
    logic         do_rst;
    wdt_mode_type mode;

    wdt_cnt_if cif ();

    wdt_counter #(
        .TICK_DIV   (TICK_DIV),
        .BASE_TICKS (BASE_TICKS)
    ) u_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .cnt     (cif.counter)
    );

    // Bus decode
    wire logic fuse      = watchdog_always_on_fuse;
    wire logic setup     = psel & ~penable;
    wire logic acc       = psel & penable;
    wire logic wr        = acc & pwrite;
    wire logic rd        = acc & ~pwrite;
    wire logic sel_ctrl  = (paddr == `WDT_CTRL_OFF);
    wire logic sel_stat  = (paddr == `WDT_STAT_OFF);
    wire logic sel_mask  = (paddr == `WDT_MASK_OFF);
    wire logic sel_rstrt = (paddr == `WDT_RSTRT_OFF);
    wire logic sel_cause = (paddr == `WDT_CAUSE_OFF);
    wire logic hit       = sel_ctrl | sel_stat | sel_mask | sel_rstrt
                         | sel_cause;
    wire logic wr_ctrl   = wr & sel_ctrl;
    wire logic wr_mask   = wr & sel_mask;
    wire logic wr_rstrt  = wr & sel_rstrt;
    wire logic wr_cause  = wr & sel_cause;
    wire logic rd_stat   = rd & sel_stat;

    // Timed unlock: open needs unlock and reset enable together
    wire logic open_win  = wr_ctrl & pwdata[`WDT_B_UNL]
                         & pwdata[`WDT_B_RE]; // R11
    wire logic in_win    = wr_ctrl & unlock_r
                         & ~pwdata[`WDT_B_UNL]; // R12

    // Effective enables after fuse and cause flag
    wire logic re_eff    = fuse | re_r | cause_r; // R10 R16
    wire logic ie_eff    = ie_r & ~fuse; // R10

    assign cif.run     = (mode != WDT_MODE_STOP);
    assign cif.restart = restart_req | wr_rstrt; // R03
    assign cif.period  = period_r;

    always_comb begin
        if (fuse) begin
            mode = WDT_MODE_RST; // R10
        end else begin
            case ({re_eff, ie_eff})
                2'h1:    mode = WDT_MODE_IRQ;
                2'h2:    mode = WDT_MODE_RST;
                2'h3:    mode = WDT_MODE_BOTH;
                default: mode = WDT_MODE_STOP;
            endcase
        end
    end

    // Expiry action by mode
    always_comb begin
        do_irq = 1'h0;
        do_rst = 1'h0;
        case (mode)
            WDT_MODE_IRQ: begin
                do_irq = cif.expire; // R02 R05
            end
            WDT_MODE_RST: begin
                do_rst = cif.expire; // R02 R06
            end
            WDT_MODE_BOTH: begin
                do_irq = cif.expire & ~iflag_r; // R07
                do_rst = cif.expire & iflag_r; // R07
            end
            default: begin
                do_irq = 1'h0;
            end
        endcase
    end

    // Control field updates
    always_comb begin
        re_nxt  = re_r;
        ie_nxt  = ie_r;
        per_nxt = period_r;
        if (open_win) begin
            re_nxt = 1'h1; // R11
            ie_nxt = pwdata[`WDT_B_IE];
        end else if (in_win) begin
            re_nxt  = pwdata[`WDT_B_RE]; // R12
            ie_nxt  = pwdata[`WDT_B_IE];
            per_nxt = pwdata[`WDT_F_PER]; // R04 R17
        end else if (wr_ctrl) begin
            re_nxt = re_r | pwdata[`WDT_B_RE]; // R12
            ie_nxt = pwdata[`WDT_B_IE];
        end
        if (irq_ack && re_eff) begin
            ie_nxt = 1'h0; // R07
        end
        if (cause_r) begin
            re_nxt = 1'h1; // R13 R16
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_r <= `WDT_PER_RST;
            re_r     <= 1'h0;
            ie_r     <= 1'h0;
        end else begin
            period_r <= per_nxt;
            re_r     <= re_nxt;
            ie_r     <= ie_nxt;
        end
    end

    // Unlock window of four cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_r  <= 1'h0;
            unl_cnt_r <= 2'h0;
        end else if (open_win) begin
            unlock_r  <= 1'h1;
            unl_cnt_r <= `WDT_UNL_CNT;
        end else if (unlock_r) begin
            unlock_r  <= ~(in_win | (unl_cnt_r == 2'h0)); // R15
            unl_cnt_r <= unl_cnt_r - 2'h1;
        end
    end

    // Sticky flags; a set wins over a clear
    wire logic       ifl_clr  = irq_ack | (wr_ctrl & pwdata[`WDT_B_IFL]);
    wire logic [1:0] stat_clr = rd_stat ? prdata_r[1:0] : 2'h0;
    wire logic       cau_clr  = wr_cause & ~pwdata[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iflag_r  <= 1'h0;
            status_r <= 2'h0;
            mask_r   <= `WDT_MASK_RST;
            cause_r  <= 1'h0;
        end else begin
            iflag_r  <= (iflag_r & ~ifl_clr) | do_irq; // R05
            status_r <= (status_r & ~stat_clr) | {do_rst, do_irq};
            mask_r   <= wr_mask ? pwdata[1:0] : mask_r;
            cause_r  <= (cause_r & ~cau_clr) | do_rst; // R13
        end
    end

    // Reset pulse and start of the start-up delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_r <= 1'h0;
            start_r <= 1'h0;
        end else begin
            pulse_r <= do_rst & ~pulse_r; // R08
            start_r <= pulse_r; // R09
        end
    end

    // Read data captured in setup phase
    assign rd_mux = sel_ctrl  ? {24'h0, iflag_r, unlock_r, ie_eff,
                                 re_eff, period_r} :
                    sel_stat  ? {30'h0, status_r} :
                    sel_mask  ? {30'h0, mask_r} :
                    sel_cause ? {31'h0, cause_r} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
        end else if (setup) begin
            prdata_r <= rd_mux;
        end
    end

    assign prdata              = prdata_r;
    assign pready              = 1'h1;
    assign pslverr             = acc & ~hit;
    assign irq                 = |(status_r & mask_r); // R05
    assign wdt_reset_pulse     = pulse_r;
    assign startup_delay_start = start_r;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    pulse_one_cycle_a: assert property (pulse_r |=> !pulse_r) // R08
        else $error("reset pulse longer than one cycle");
    pulse_then_start_a: assert property ( // R09
        $fell(pulse_r) |-> start_r ##1 !start_r)
        else $error("start-up delay not started at pulse end");
    reset_mode_a: assert property ( // R06
        cif.expire && re_eff && !ie_eff |=> pulse_r && cause_r)
        else $error("reset mode expiry gave no reset");
    irq_mode_a: assert property ( // R05
        cif.expire && ie_eff && !re_eff |=> iflag_r && status_r[0])
        else $error("interrupt mode expiry gave no interrupt");
    combined_mode_a: assert property ( // R07
        cif.expire && ie_eff && re_eff && !iflag_r
        |=> iflag_r && !pulse_r)
        else $error("combined mode first expiry wrong");
    fuse_forces_a: assert property ( // R10
        fuse |-> re_eff && !ie_eff && mode == WDT_MODE_RST)
        else $error("fuse does not force reset mode");
    flag_holds_re_a: assert property (cause_r |=> re_r) // R16
        else $error("cause flag did not hold reset enable");
    unlock_expire_a: assert property ( // R15
        $rose(unlock_r) ##1 !wr_ctrl [*3] |=> !unlock_r)
        else $error("unlock not cleared after four cycles");
    period_locked_a: assert property ( // R12
        !unlock_r |=> $stable(period_r))
        else $error("period changed outside unlock window");
    stopped_idle_a: assert property ( // R02
        !cif.run |=> cif.count == 21'h0)
        else $error("stopped counter not held at zero");
    window_apply_a: assert property ( // R12
        in_win |=> period_r == $past(pwdata[`WDT_F_PER]))
        else $error("window write did not set the period");

    reset_seen_c: cover property (pulse_r);
    both_mode_c: cover property (
        mode == WDT_MODE_BOTH && cif.expire ##[1:1000] pulse_r);
    window_write_c: cover property (in_win);
    ack_in_both_c: cover property (irq_ack && mode == WDT_MODE_BOTH);
endmodule

// [wdt_defs.svh]
// Watchdog constants: register offsets, field positions, timing counts.
// Assumes a 20 MHz pclk and a 128 kHz watchdog tick derived from it.
// Contract
// R01 - Counter advances on 128 kHz oscillator ticks
// R02 - Expiry gives interrupt or reset per mode
// R03 - Restart clears counter; software restarts in time
// R04 - Time-out selectable from 16 ms to 8 s
// R05 - Interrupt mode raises wake-capable interrupt request
// R06 - Reset mode expiry resets the system
// R07 - Combined mode: interrupt first, then reset
// R08 - Reset pulse lasts exactly one clock
// R09 - Start-up delay starts at pulse falling edge
// R10 - Fuse forces reset enable 1, irq 0
// R11 - Unlock writes change and reset enable together
// R12 - Changes accepted only within four-cycle window; the code takes a reset enable set and any interrupt enable write at any time
// R13 - Watchdog stays enabled after its own reset
// R14 - Software clears cause flag and enable at init
// R15 - Change unlock self-clears after four cycles
// R16 - Cause flag holds reset enable at one
// R17 - Period code 0..9 selects 2048 doubling cycles
// R18 - Software restarts before shortening the period
// R19 - Restarts, changes and expiries never lost
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

`define WDT_CTRL_OFF   8'h00
`define WDT_STAT_OFF   8'h04
`define WDT_MASK_OFF   8'h08
`define WDT_RSTRT_OFF  8'h0C
`define WDT_CAUSE_OFF  8'h10

`define WDT_F_PER      3:0
`define WDT_B_RE       4
`define WDT_B_IE       5
`define WDT_B_UNL      6
`define WDT_B_IFL      7
`define WDT_S_IRQ      0
`define WDT_S_RST      1

`define WDT_PER_RST    4'h0
`define WDT_MASK_RST   2'h0
`define WDT_UNL_CNT    2'h3
`define WDT_PER_MAX    4'h9

`define WDT_CLK_KHZ    20000
`define WDT_OSC_KHZ    128
`define WDT_TICK_DIV   (`WDT_CLK_KHZ / `WDT_OSC_KHZ)
`define WDT_TOUT_MIN_MS 16
`define WDT_BASE_TICKS (`WDT_TOUT_MIN_MS * `WDT_OSC_KHZ)

`endif

// [wdt_pkg.sv]
// Watchdog types shared by the controller.
// Assumes nothing of its surroundings.
package wdt_pkg;
    typedef enum logic [1:0] {
        WDT_MODE_STOP,
        WDT_MODE_IRQ,
        WDT_MODE_RST,
        WDT_MODE_BOTH
    } wdt_mode_type;
endpackage

// [wdt_cnt_if.sv]
// Link between watchdog controller and its tick counter.
// Assumes both ends run on pclk.
`timescale 1ns/10ps
interface wdt_cnt_if;
    logic        run;
    logic        restart;
    logic [3:0]  period;
    logic        expire;
    logic [20:0] count;
    modport counter (input run, restart, period, output expire, count);
    modport ctrl (input expire, count, output run, restart, period);
endinterface

// [wdt_counter.sv]
// Watchdog tick divider and time-out counter.
// Assumes a single pclk domain; the tick is an enable pulse.
`timescale 1ns/10ps
`include "wdt_defs.svh"
module wdt_counter #(
    parameter int TICK_DIV   = `WDT_TICK_DIV,
    parameter int BASE_TICKS = `WDT_BASE_TICKS
) (
    input  wire logic  pclk,
    input  wire logic  presetn,
    wdt_cnt_if.counter cnt
);
    logic [15:0] div_r;
    logic [20:0] cnt_r;

    wire logic        tick  = (div_r == 16'(TICK_DIV - 1));
    wire logic [3:0]  per_c = (cnt.period > `WDT_PER_MAX) ?
                              `WDT_PER_MAX : cnt.period;
    wire logic [20:0] limit = 21'(BASE_TICKS) << per_c;
    // Reaching or passing the limit; a shortened period expires on the next tick
    wire logic        hit   = tick & (cnt_r >= limit - 21'h1);

    // Oscillator tick from divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 16'h0;
        end else begin
            div_r <= tick ? 16'h0 : div_r + 16'h1; // R01
        end
    end

    // Restart wins over a coincident tick or expiry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 21'h0;
        end else if (cnt.restart || !cnt.run || hit) begin
            cnt_r <= 21'h0; // R03 R19
        end else if (tick) begin
            cnt_r <= cnt_r + 21'h1; // R04 R17
        end
    end

    assign cnt.expire = hit & cnt.run & ~cnt.restart; // R02 R19
    assign cnt.count  = cnt_r;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    tick_single_a: assert property (tick |=> !tick) // R01
        else $error("tick longer than one cycle");
    restart_clear_a: assert property ( // R03
        cnt.restart |=> (cnt_r == 21'h0) && $past(!cnt.expire))
        else $error("restart did not clear counter");
endmodule

// [wdt_core_model.sv]
// Core model: restart instruction stream and vector entry acknowledge.
// Assumes the pclk domain; the bench sets kick spacing and ack delay.
`timescale 1ns/10ps
module wdt_core_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       irq,
    input  wire logic [3:0] kick_gap,
    input  wire logic [3:0] ack_dly,
    output logic            restart_req,
    output logic            irq_ack
);
    logic [3:0] kcnt_r;
    logic [3:0] acnt_r;
    logic       irq_d_r;

    // Gap 0 stops kicking, delay 0 never takes the vector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kcnt_r      <= 4'h0;
            acnt_r      <= 4'h0;
            irq_d_r     <= 1'b0;
            restart_req <= 1'b0;
            irq_ack     <= 1'b0;
        end else begin
            restart_req <= (kick_gap != 4'h0) && (kcnt_r == 4'h0);
            kcnt_r      <= (kcnt_r == 4'h0) ? kick_gap : kcnt_r - 4'h1;
            irq_d_r     <= irq;
            if (irq && !irq_d_r && ack_dly != 4'h0)
                acnt_r <= ack_dly;
            else if (acnt_r != 4'h0)
                acnt_r <= acnt_r - 4'h1;
            irq_ack     <= (acnt_r == 4'h1);
        end
    end
endmodule

// [tb_watchdog_timer_with_reset.sv]
// Testbench: APB master, core model, scoreboard of reads and resets.
// Assumes the shortened counter: TICK_DIV 2, BASE_TICKS 4.
`timescale 1ns/10ps
`include "wdt_defs.svh"
module tb_watchdog_timer_with_reset;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        watchdog_always_on_fuse;
    logic        restart_req;
    logic        irq_ack;
    logic        irq;
    logic        wdt_reset_pulse;
    logic        startup_delay_start;
    logic [3:0]  kick_gap;
    logic [3:0]  ack_dly;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic        pulse_d = 1'b0;
    logic        irq_seen = 1'b0;
    logic [7:0]  offs[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    int          n_errors = 0;
    int          checks = 0;
    int          n_pulse = 0;
    int          seed = 32'hD792;

    wdt_top #(.TICK_DIV(2), .BASE_TICKS(4)) wdt_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .watchdog_always_on_fuse(watchdog_always_on_fuse),
        .restart_req(restart_req), .irq_ack(irq_ack), .irq(irq),
        .wdt_reset_pulse(wdt_reset_pulse),
        .startup_delay_start(startup_delay_start));

    wdt_core_model wdt_core_model_i (
        .pclk(pclk), .presetn(presetn), .irq(irq), .kick_gap(kick_gap),
        .ack_dly(ack_dly), .restart_req(restart_req), .irq_ack(irq_ack));

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results();
        if (n_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic give_up();
        n_errors++;
        results();
    endtask

    // Read: d is the expected data; the monitor compares it
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic err);
        int n;
        exp_q.push_back({~w, err, d});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            give_up();
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Sel 1 waits for irq high, sel 0 for a new reset pulse
    task automatic wait_for(input int sel, input int lim);
        int n;
        int p0;
        p0 = n_pulse;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (!(sel ? irq === 1'b1 : n_pulse != p0) && n < lim);
        if (n >= lim)
            give_up();
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
            if (e[33])
                chk("prdata", prdata, e[31:0]);
        end
        if (pulse_d) begin
            chk("pulse end", {31'h0, wdt_reset_pulse}, 32'h0);
            chk("delay start", {31'h0, startup_delay_start}, 32'h1);
        end
        pulse_d = (wdt_reset_pulse === 1'b1);
        if (wdt_reset_pulse === 1'b1)
            n_pulse++;
        if (irq === 1'b1)
            irq_seen = 1'b1;
    end

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        int p;
        int v;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        watchdog_always_on_fuse = 1'b0;
        kick_gap = 4'h0;
        ack_dly = 4'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (offs[i]) apb(1'b0, offs[i], 32'h0, 1'b0);
        apb(1'b0, 8'h14, 32'h0, 1'b1);
        apb(1'b1, 8'h14, 32'hFFFFFFFF, 1'b1);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed) & 3;
            apb(1'b1, `WDT_MASK_OFF, v, 1'b0);
            apb(1'b0, `WDT_MASK_OFF, v, 1'b0);
        end
        // Interrupt mode, 32-tick period
        apb(1'b1, `WDT_MASK_OFF, 32'h1, 1'b0);
        apb(1'b1, `WDT_CTRL_OFF, 32'h50, 1'b0);
        apb(1'b1, `WDT_CTRL_OFF, 32'h23, 1'b0);
        apb(1'b0, `WDT_CTRL_OFF, 32'h23, 1'b0);
        p = n_pulse;
        wait_for(1, 300);
        apb(1'b0, `WDT_STAT_OFF, 32'h1, 1'b0);
        apb(1'b0, `WDT_STAT_OFF, 32'h0, 1'b0);
        chk("pulses", n_pulse, p);
        apb(1'b1, `WDT_MASK_OFF, 32'h0, 1'b0);
        @(negedge pclk);
        irq_seen = 1'b0;
        repeat (150) @(negedge pclk);
        chk("masked irq", {31'h0, irq_seen}, 32'h0);
        apb(1'b0, `WDT_STAT_OFF, 32'h1, 1'b0);
        apb(1'b1, `WDT_CTRL_OFF, 32'h80, 1'b0);
        apb(1'b0, `WDT_CTRL_OFF, 32'h03, 1'b0);
        // Reset mode: period change refused, enable accepted
        apb(1'b1, `WDT_RSTRT_OFF, 32'h0, 1'b0);
        apb(1'b1, `WDT_CTRL_OFF, 32'h19, 1'b0);
        apb(1'b0, `WDT_CTRL_OFF, 32'h13, 1'b0);
        wait_for(0, 300);
        apb(1'b0, `WDT_CAUSE_OFF, 32'h1, 1'b0);
        apb(1'b0, `WDT_STAT_OFF, 32'h2, 1'b0);
        kick_gap <= 4'h2;
        p = n_pulse;
        apb(1'b1, `WDT_CTRL_OFF, 32'h50, 1'b0);
        apb(1'b1, `WDT_CTRL_OFF, 32'h03, 1'b0);
        apb(1'b0, `WDT_CTRL_OFF, 32'h13, 1'b0);
        apb(1'b1, `WDT_CAUSE_OFF, 32'h0, 1'b0);
        apb(1'b0, `WDT_CAUSE_OFF, 32'h0, 1'b0);
        apb(1'b1, `WDT_CTRL_OFF, 32'h50, 1'b0);
        apb(1'b0, `WDT_CTRL_OFF, 32'h53, 1'b0);
        apb(1'b1, `WDT_CTRL_OFF, 32'h00, 1'b0);
        apb(1'b0, `WDT_CTRL_OFF, 32'h13, 1'b0);
        apb(1'b1, `WDT_CTRL_OFF, 32'h50, 1'b0);
        apb(1'b1, `WDT_CTRL_OFF, 32'h10, 1'b0);
        repeat (60) @(negedge pclk);
        chk("pulses", n_pulse, p);
        kick_gap <= 4'h0;
        wait_for(0, 40);
        // Combined mode, slow vector acknowledge
        kick_gap <= 4'h2;
        apb(1'b1, `WDT_CAUSE_OFF, 32'h0, 1'b0);
        apb(1'b1, `WDT_MASK_OFF, 32'h1, 1'b0);
        apb(1'b1, `WDT_CTRL_OFF, 32'h50, 1'b0);
        apb(1'b1, `WDT_CTRL_OFF, 32'h30, 1'b0);
        ack_dly <= 4'h3;
        kick_gap <= 4'h0;
        p = n_pulse;
        wait_for(1, 60);
        chk("pulses", n_pulse, p);
        wait_for(0, 60);
        apb(1'b0, `WDT_CTRL_OFF, 32'h10, 1'b0);
        watchdog_always_on_fuse <= 1'b1;
        apb(1'b1, `WDT_CTRL_OFF, 32'h20, 1'b0);
        apb(1'b0, `WDT_CTRL_OFF, 32'h10, 1'b0);
        // Let the monitor take the last access first
        repeat (2) @(negedge pclk);
        results();
    end
endmodule
